// [rtl/dpw_wiper_control.sv]
// control register and wiper code logic of a two channel potentiometer
// assumes commands arrive already decoded, one per clock, synchronous
//
// What this block does
// - control bit 0 clear freezes wipers to stored
// - control bit 1 gates nonvolatile programming
// - control bit 2 selects linear gain mode
// - control bit 3 burst, sticky until cleared
// - wiper code decodes to one of 256 taps
// - wiper to b grows with code
// - a to wiper complementary in potentiometer mode
// - a to wiper proportional in linear mode
// - top scale sets a to wiper to zero
// - write-control command loads low four bits
// - power-up preset restores stored wiper values
`timescale 1ns/10ps
`default_nettype none
module dpw_wiper_control
   import dpw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // decoded command
   input wire dpw_pkg::dpw_cmd_s cmd,
   // nonvolatile store
   input wire logic [dpw_pkg::NUM_CH*dpw_pkg::CODE_W-1:0] nv_code,
   output logic nv_prog,
   output logic [dpw_pkg::CODE_W-1:0] nv_prog_data,
   output logic nv_prog_ch,
   // state
   output logic [dpw_pkg::CTL_W-1:0] wiper_control_config,
   output logic burst_mode,
   output logic preset_busy,
   output logic [dpw_pkg::NUM_CH*dpw_pkg::CODE_W-1:0] wiper_code_register,
   output dpw_pkg::dpw_tap_s [dpw_pkg::NUM_CH-1:0] tap
);
   import dpw_pkg::*;

   // ************************************************************
   // decode helpers
   // ************************************************************
   function automatic logic ch_hit(input logic [3:0] a, input int ch);
      ch_hit = a[3] || (a[0] == ch[0]);
   endfunction

   // ************************************************************
   // state
   // ************************************************************
   dpw_state_e state_q, state_d;
   logic [CTL_W-1:0] ctl_q, ctl_d;
   logic [CODE_W-1:0] code_q [NUM_CH];
   logic [CODE_W-1:0] code_d [NUM_CH];
   logic [NUM_CH-1:0] top_q, top_d, bot_q, bot_d;
   logic prog_q, prog_d, prog_ch_q, prog_ch_d;
   logic [CODE_W-1:0] prog_data_q, prog_data_d;
   logic run;

   assign run = (state_q == DPW_RUN);

   always_comb begin
      state_d = DPW_RUN;
      ctl_d = ctl_q;
      top_d = top_q;
      bot_d = bot_q;
      prog_d = 1'b0;
      prog_ch_d = prog_ch_q;
      prog_data_d = prog_data_q;
      for (int i = 0; i < NUM_CH; i++) begin
         code_d[i] = code_q[i];
      end
      if (!run) begin
         // power-up preset copies stored codes
         for (int i = 0; i < NUM_CH; i++) begin
            code_d[i] = nv_code[i*CODE_W +: CODE_W];
         end
      end else if (cmd.valid) begin
         case (cmd.op)
            CMD_WR_CONTROL: begin
               ctl_d = cmd.data[CTL_W-1:0];
            end
            CMD_WR_WIPER: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (ch_hit(cmd.addr, i) && ctl_q[CTL_WR_EN_BIT]) begin
                     code_d[i] = cmd.data;
                     top_d[i] = 1'b0;
                     bot_d[i] = 1'b0;
                  end
               end
            end
            CMD_SCALE: begin
               for (int i = 0; i < NUM_CH; i++) begin
                  if (ch_hit(cmd.addr, i) && ctl_q[CTL_WR_EN_BIT]) begin
                     if (cmd.data[SCALE_TOP_BIT]) begin
                        top_d[i] = cmd.data[SCALE_ENTER_BIT];
                        bot_d[i] = 1'b0;
                     end else begin
                        bot_d[i] = cmd.data[SCALE_ENTER_BIT];
                        top_d[i] = 1'b0;
                     end
                  end
               end
            end
            CMD_WIPER_TO_NV: begin
               if (ctl_q[CTL_PROG_EN_BIT]) begin
                  prog_d = 1'b1;
                  prog_ch_d = cmd.addr[0];
                  prog_data_d = cmd.addr[0] ? code_q[1] : code_q[0];
               end
            end
            CMD_SOFT_RESET: begin
               state_d = DPW_PRESET;
               top_d = '0;
               bot_d = '0;
            end
            default: begin
               state_d = DPW_RUN;
            end
         endcase
      end
      if (run && !ctl_q[CTL_WR_EN_BIT]) begin
         // frozen to stored values
         for (int i = 0; i < NUM_CH; i++) begin
            code_d[i] = nv_code[i*CODE_W +: CODE_W];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q <= DPW_PRESET;
         ctl_q <= CTL_RESET;
         top_q <= '0;
         bot_q <= '0;
         prog_q <= 1'b0;
         prog_ch_q <= 1'b0;
         prog_data_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            code_q[i] <= '0;
         end
      end else begin
         state_q <= state_d;
         ctl_q <= ctl_d;
         top_q <= top_d;
         bot_q <= bot_d;
         prog_q <= prog_d;
         prog_ch_q <= prog_ch_d;
         prog_data_q <= prog_data_d;
         for (int i = 0; i < NUM_CH; i++) begin
            code_q[i] <= code_d[i];
         end
      end
   end

   // ************************************************************
   // tap decode per channel
   // ************************************************************
   dpw_tap_s tap_d [NUM_CH];
   dpw_tap_s tap_q [NUM_CH];

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      always_comb begin
         // wiper to b grows with code
         tap_d[g].wiper_to_b = {1'b0, code_q[g]};
         if (ctl_q[CTL_LINEAR_BIT]) begin
            tap_d[g].a_to_wiper = {1'b0, code_q[g]};
         end else begin
            tap_d[g].a_to_wiper = TAP_COUNT - {1'b0, code_q[g]};
         end
         if (top_q[g]) begin
            // one step above highest normal code
            tap_d[g].wiper_to_b = TAP_COUNT;
            tap_d[g].a_to_wiper = 9'h0;
         end else if (bot_q[g]) begin
            tap_d[g].wiper_to_b = 9'h0;
            tap_d[g].a_to_wiper = TAP_COUNT;
         end
      end
      always_ff @(posedge clk or negedge reset_n) begin
         if (!reset_n) begin
            tap_q[g] <= '0;
         end else begin
            tap_q[g] <= tap_d[g];
         end
      end
      assign tap[g] = tap_q[g];
      assign wiper_code_register[g*CODE_W +: CODE_W] = code_q[g];
   end

   assign wiper_control_config = ctl_q;
   assign burst_mode = ctl_q[CTL_BURST_BIT];
   assign preset_busy = !run;
   assign nv_prog = prog_q;
   assign nv_prog_data = prog_data_q;
   assign nv_prog_ch = prog_ch_q;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   sequence s_ctl_write;
      run && cmd.valid && cmd.op == CMD_WR_CONTROL;
   endsequence

   a_ctl_load: assert property (s_ctl_write |=>
      ctl_q == $past(cmd.data[3:0])) else $error("control load wrong");
   a_burst_hold: assert property (burst_mode &&
      !(cmd.valid && cmd.op == CMD_WR_CONTROL) |=> burst_mode)
      else $error("burst dropped");
   a_frozen_wiper: assert property (run && !ctl_q[0] |=>
      wiper_code_register == $past(nv_code)) else $error("wiper not frozen");
   a_prog_gate: assert property (!ctl_q[1] |=> !nv_prog)
      else $error("program while disabled");
   a_preset_load: assert property (!run |=>
      wiper_code_register == $past(nv_code)) else $error("preset missed");
   a_pot_sum: assert property (!ctl_q[2] && !top_q[0] && !bot_q[0] |=>
      tap[0].a_to_wiper + tap[0].wiper_to_b == TAP_COUNT)
      else $error("pot not complementary");
   a_linear_eq: assert property (ctl_q[2] && !top_q[0] && !bot_q[0] |=>
      tap[0].a_to_wiper == tap[0].wiper_to_b) else $error("linear wrong");
   a_wb_code: assert property (!top_q[1] && !bot_q[1] |=>
      tap[1].wiper_to_b == {1'b0, $past(code_q[1])})
      else $error("wiper to b wrong");
   a_top_scale: assert property (top_q[0] |=>
      tap[0].a_to_wiper == 9'h0) else $error("top scale wrong");
endmodule
`default_nettype wire

// [rtl/dpw_pkg.sv]
// package for the digital potentiometer wiper control block
// assumes a decoded command stream from the serial front end
package dpw_pkg;
   // ************************************************************
   // widths and counts
   // ************************************************************
   localparam int CODE_W = 8;
   localparam int NUM_CH = 2;
   localparam logic [8:0] TAP_COUNT = 9'h100;
   localparam logic [CODE_W-1:0] CODE_MAX = 8'hff;
   // ************************************************************
   // control register fields and reset value
   // ************************************************************
   localparam int CTL_W = 4;
   localparam int CTL_WR_EN_BIT = 0;
   localparam int CTL_PROG_EN_BIT = 1;
   localparam int CTL_LINEAR_BIT = 2;
   localparam int CTL_BURST_BIT = 3;
   localparam logic [CTL_W-1:0] CTL_RESET = 4'h3;
   // ************************************************************
   // command codes (upper nibble of the command word)
   // ************************************************************
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WR_WIPER = 4'h1;
   localparam logic [3:0] CMD_WIPER_TO_NV = 4'h7;
   localparam logic [3:0] CMD_SCALE = 4'h9;
   localparam logic [3:0] CMD_SOFT_RESET = 4'hb;
   localparam logic [3:0] CMD_WR_CONTROL = 4'hd;
   localparam int SCALE_TOP_BIT = 7;
   localparam int SCALE_ENTER_BIT = 0;

   typedef enum logic [1:0] {
      DPW_PRESET = 2'b00,
      DPW_RUN = 2'b01
   } dpw_state_e;

   typedef struct packed {
      logic valid;
      logic [3:0] op;
      logic [3:0] addr;
      logic [7:0] data;
   } dpw_cmd_s;

   typedef struct packed {
      logic [8:0] a_to_wiper;
      logic [8:0] wiper_to_b;
   } dpw_tap_s;
endpackage

// [verif/dpw_host_model.sv]
// host model that issues decoded wiper commands
// assumes the block samples cmd on the rising edge of clk
`timescale 1ns/10ps
`default_nettype none
module dpw_host_model
   import dpw_pkg::*;
(
   // clock
   input wire logic clk,
   // command out
   output dpw_pkg::dpw_cmd_s cmd
);
   // ************************************************************
   // command issue
   // ************************************************************
   initial cmd = '0;
   // one command, valid for exactly one cycle
   task automatic send(input logic [3:0] op, input logic [3:0] addr,
      input logic [7:0] data);
      @(posedge clk);
      cmd <= '{valid: 1'b1, op: op, addr: addr, data: data};
      @(posedge clk);
      cmd <= '0;
   endtask
endmodule
`default_nettype wire

// [verif/dpw_wiper_control_test.sv]
// self-checking bench for the wiper control block
// assumes the host model drives commands; the stored codes live here
`timescale 1ns/10ps
`default_nettype none
module dpw_wiper_control_test;
   import dpw_pkg::*;
   logic clk;
   logic reset_n;
   logic [15:0] nv_code;
   dpw_cmd_s cmd;
   logic nv_prog;
   logic [7:0] nv_prog_data;
   logic nv_prog_ch;
   logic [3:0] ctl;
   logic burst_mode;
   logic preset_busy;
   logic [15:0] code;
   dpw_tap_s [1:0] tap;
   int num_errors;
   int checked;
   int i;
   // ************************************************************
   // clock, store and instances
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   // stored code model takes program pulses
   always @(posedge clk) begin
      if (!reset_n) begin
         nv_code <= 16'h5aa5;
      end else if (nv_prog === 1'b1) begin
         nv_code[nv_prog_ch*8 +: 8] <= nv_prog_data;
      end
   end
   dpw_host_model dpw_host_model_inst (.clk(clk), .cmd(cmd));
   dpw_wiper_control dpw_wiper_control_inst (
      .clk(clk), .reset_n(reset_n), .cmd(cmd), .nv_code(nv_code),
      .nv_prog(nv_prog), .nv_prog_data(nv_prog_data),
      .nv_prog_ch(nv_prog_ch), .wiper_control_config(ctl),
      .burst_mode(burst_mode), .preset_busy(preset_busy),
      .wiper_code_register(code), .tap(tap));
   // ************************************************************
   // tasks
   // ************************************************************
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      checked++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic send(input logic [3:0] op, input logic [3:0] addr,
      input logic [7:0] data);
      dpw_host_model_inst.send(op, addr, data);
      #1;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask
   task automatic print_verdict();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic run_tests();
      chk(ctl, 4'h3);
      chk(code, 16'h5aa5);
      send(CMD_WR_WIPER, 4'h0, 8'h40);
      settle();
      chk(code[7:0], 8'h40);
      chk(tap[0].wiper_to_b, 9'h040);
      chk(tap[0].a_to_wiper, 9'h0c0);
      send(CMD_WIPER_TO_NV, 4'h0, 8'h01);
      chk({nv_prog_ch, nv_prog, nv_prog_data}, {2'b01, 8'h40});
      send(CMD_SCALE, 4'h1, 8'h81);
      settle();
      chk(tap[1], {9'h000, 9'h100});
      send(CMD_WR_CONTROL, 4'h0, 8'h05);
      send(CMD_WR_WIPER, 4'h0, 8'h20);
      settle();
      chk(ctl, 4'h5);
      chk(tap[0], {9'h020, 9'h020});
      send(CMD_WR_CONTROL, 4'h0, 8'h08);
      chk({burst_mode, ctl}, 5'h18);
      send(CMD_WIPER_TO_NV, 4'h0, 8'h01);
      chk(nv_prog, 1'b0);
      send(CMD_WR_WIPER, 4'h0, 8'h11);
      settle();
      chk(code, 16'h5a40);
      chk(burst_mode, 1'b1);
      send(CMD_WR_CONTROL, 4'h0, 8'h03);
      send(CMD_WR_WIPER, 4'h8, 8'h66);
      settle();
      chk(code, 16'h6666);
      send(CMD_SCALE, 4'h0, 8'h01);
      settle();
      chk(tap[0], {9'h100, 9'h000});
      send(CMD_SCALE, 4'h0, 8'h81);
      settle();
      chk(tap[0], {9'h000, 9'h100});
      send(CMD_SOFT_RESET, 4'h0, 8'h00);
      chk(preset_busy, 1'b1);
      settle();
      chk(code, 16'h5a40);
      chk(tap[1], {9'h0a6, 9'h05a});
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      num_errors = 0;
      checked = 0;
      reset_n = 1'b0;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      for (i = 0; i < 10; i++) begin
         @(posedge clk);
         #1;
         if (preset_busy === 1'b0) break;
      end
      if (preset_busy !== 1'b0) begin
         num_errors++;
      end else begin
         run_tests();
      end
      print_verdict();
   end
endmodule
`default_nettype wire
